// file: ocal_calib.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Selector code 0 picks the slow RC oscillator, 1 the fast RC, 2 the slow crystal and 3 the extended RC.
// - Writing one to the go bit while idle starts a run on the oscillator that the same write selects.
// - The go bit reads one while a run is active and drops to zero only when the result is valid.
// - Gate select zero lets the source clock enable the reference counter, one also requires an external input to be high.
// - The window length loads a down-counter that steps once per source cycle and ends the window at one or below.
// - Reference clock cycles are counted over the window, only while the gate input is high in gate mode, and reported as a read-only total.
// - The 32-bit total is read as two 16-bit words, low half at the lower address, high half at the next.
// - After reset selector, gate select, go bit, window length and both result halves read zero.
module ocal_calib (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire ocal_pkg::ocal_req_t req,
   output logic [15:0] rdata,
   // Oscillator and gate pins
   input wire ocal_pkg::ocal_osc_t osc,
   input wire logic ext_gate,
   // Interrupt
   output logic irq
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [ocal_pkg::PIN_N-1:0] pins;
   logic [ocal_pkg::PIN_N-1:0] sync1_q;
   logic [ocal_pkg::PIN_N-1:0] sync2_q;
   logic [ocal_pkg::PIN_N-1:0] sync3_q;
   logic [ocal_pkg::PIN_N-1:0] filt_q;
   ocal_pkg::ocal_state_t state_q;
   logic [1:0] sel_q;
   logic gate_sel_q;
   logic [1:0] run_sel_q;
   logic run_gate_q;
   logic [15:0] window_q;
   logic [15:0] down_q;
   logic [31:0] count_q;
   logic [31:0] count_nxt;
   logic [31:0] result_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic [15:0] rdata_q;
   logic src_lvl;
   logic [ocal_pkg::PIN_N-1:0] prev_q;
   logic src_edge;
   logic busy;
   logic wr_ctrl;
   logic start;
   logic cnt_en;
   logic sat;
   logic win_end;
   logic [1:0] ev_set;
   logic [1:0] ev_clr;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************

   // Index order matches the selector codes, gate input on top
   assign pins = {ext_gate, osc.ext_rc, osc.slow_xtal, osc.fast_rc, osc.slow_rc};

   // Three stages per pin, a change is taken once stages two and three agree
   generate
      for (genvar i = 0; i < ocal_pkg::PIN_N; i++) begin : g_sync
         always_ff @(posedge clk) begin
            if (srst) begin
               sync1_q[i] <= 1'b0;
               sync2_q[i] <= 1'b0;
               sync3_q[i] <= 1'b0;
               filt_q[i] <= 1'b0;
            end else begin
               sync1_q[i] <= pins[i];
               sync2_q[i] <= sync1_q[i];
               sync3_q[i] <= sync2_q[i];
               if (sync2_q[i] == sync3_q[i]) begin
                  filt_q[i] <= sync3_q[i];
               end
            end
         end
      end
   endgenerate

   // Source picked by the code latched at start; a source near clk rate cannot be resolved
   assign src_lvl = filt_q[run_sel_q];
   assign src_edge = src_lvl & ~prev_q[run_sel_q];

   // Previous level of every pin, so a new selector at start gives no false edge
   always_ff @(posedge clk) begin
      if (srst) begin
         prev_q <= {ocal_pkg::PIN_N{1'b0}};
      end else begin
         prev_q <= filt_q;
      end
   end

   // ************************************************************
   // Control decode
   // ************************************************************

   // Start only from idle, a go write during a run is ignored
   assign busy = (state_q != ocal_pkg::ST_IDLE);
   assign wr_ctrl = req.wr && (req.addr == ocal_pkg::OFF_CONTROL);
   assign start = wr_ctrl && req.wdata[ocal_pkg::CTRL_GO_BIT] && !busy;

   // Counter enable from the source window, and also the external gate when gate select is set
   assign cnt_en = (state_q == ocal_pkg::ST_MEASURE) && (!run_gate_q || filt_q[ocal_pkg::PIN_GATE]);
   assign sat = (count_q == 32'hFFFF_FFFF);
   assign count_nxt = (cnt_en && !sat) ? count_q + 32'h0000_0001 : count_q;

   // Window closes on the source edge that finds the down-counter at one or below
   assign win_end = (state_q == ocal_pkg::ST_MEASURE) && src_edge && (down_q <= ocal_pkg::WINDOW_LAST);

   // ************************************************************
   // Configuration registers
   // ************************************************************

   // Selector and gate select, writable at any time
   always_ff @(posedge clk) begin
      if (srst) begin
         sel_q <= ocal_pkg::CTRL_RST[1:0];
         gate_sel_q <= ocal_pkg::CTRL_RST[ocal_pkg::CTRL_GATE_BIT];
      end else if (wr_ctrl) begin
         sel_q <= req.wdata[ocal_pkg::CTRL_SEL_LSB +: 2];
         gate_sel_q <= req.wdata[ocal_pkg::CTRL_GATE_BIT];
      end
   end

   // Window length register
   always_ff @(posedge clk) begin
      if (srst) begin
         window_q <= ocal_pkg::WINDOW_RST;
      end else if (req.wr && (req.addr == ocal_pkg::OFF_WINDOW)) begin
         window_q <= req.wdata;
      end
   end

   // Interrupt mask register
   always_ff @(posedge clk) begin
      if (srst) begin
         mask_q <= ocal_pkg::IRQ_RST;
      end else if (req.wr && (req.addr == ocal_pkg::OFF_IRQ_MASK)) begin
         mask_q <= req.wdata[ocal_pkg::IRQ_W-1:0];
      end
   end

   // ************************************************************
   // Measurement sequencer
   // ************************************************************

   // Idle, wait for the first source edge, then measure
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= ocal_pkg::ST_IDLE;
      end else begin
         case (state_q)
            ocal_pkg::ST_IDLE: begin
               if (start) begin
                  state_q <= ocal_pkg::ST_ARM;
               end
            end
            ocal_pkg::ST_ARM: begin
               if (src_edge) begin
                  state_q <= ocal_pkg::ST_MEASURE;
               end
            end
            ocal_pkg::ST_MEASURE: begin
               if (win_end) begin
                  state_q <= ocal_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= ocal_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Run settings latched at start so a write mid-run cannot disturb it
   always_ff @(posedge clk) begin
      if (srst) begin
         run_sel_q <= ocal_pkg::SRC_SLOW_RC;
         run_gate_q <= 1'b0;
      end else if (start) begin
         run_sel_q <= req.wdata[ocal_pkg::CTRL_SEL_LSB +: 2];
         run_gate_q <= req.wdata[ocal_pkg::CTRL_GATE_BIT];
      end
   end

   // Window down-counter, one step per source cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         down_q <= ocal_pkg::WINDOW_RST;
      end else if (start) begin
         down_q <= window_q;
      end else if ((state_q == ocal_pkg::ST_MEASURE) && src_edge && !win_end) begin
         down_q <= down_q - 16'h0001;
      end
   end

   // Reference cycle counter, cleared at start and saturating
   always_ff @(posedge clk) begin
      if (srst) begin
         count_q <= ocal_pkg::RESULT_RST;
      end else if (start) begin
         count_q <= ocal_pkg::RESULT_RST;
      end else begin
         count_q <= count_nxt;
      end
   end

   // Result copied only at window end, stable otherwise
   always_ff @(posedge clk) begin
      if (srst) begin
         result_q <= ocal_pkg::RESULT_RST;
      end else if (win_end) begin
         result_q <= count_nxt;
      end
   end

   // ************************************************************
   // Interrupt status
   // ************************************************************

   // Done and saturation events
   assign ev_set[ocal_pkg::IRQ_DONE_BIT] = win_end;
   assign ev_set[ocal_pkg::IRQ_OVF_BIT] = cnt_en && sat;
   assign ev_clr = (req.wr && (req.addr == ocal_pkg::OFF_IRQ_STATUS)) ? req.wdata[ocal_pkg::IRQ_W-1:0] : 2'h0;

   // Sticky bits, write one to clear, a new event beats the clear
   always_ff @(posedge clk) begin
      if (srst) begin
         status_q <= ocal_pkg::IRQ_RST;
      end else begin
         status_q <= (status_q & ~ev_clr) | ev_set;
      end
   end

   assign irq = |(status_q & mask_q);

   // ************************************************************
   // Read port
   // ************************************************************

   // Read data one cycle after the strobe, zero otherwise or unmapped
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 16'h0000;
      end else if (req.rd) begin
         case (req.addr)
            ocal_pkg::OFF_CONTROL: begin
               rdata_q <= {12'h000, gate_sel_q, busy, sel_q};
            end
            ocal_pkg::OFF_WINDOW: begin
               rdata_q <= window_q;
            end
            ocal_pkg::OFF_RESULT_LO: begin
               rdata_q <= result_q[15:0];
            end
            ocal_pkg::OFF_RESULT_HI: begin
               rdata_q <= result_q[31:16];
            end
            ocal_pkg::OFF_IRQ_STATUS: begin
               rdata_q <= {14'h0000, status_q};
            end
            ocal_pkg::OFF_IRQ_MASK: begin
               rdata_q <= {14'h0000, mask_q};
            end
            default: begin
               rdata_q <= 16'h0000;
            end
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign rdata = rdata_q;

   // ************************************************************
   // Assertions
   // ************************************************************

   // Start latches the selector and arms the run
   property p_start_sel;
      @(posedge clk) disable iff (srst)
      start |=> (run_sel_q == $past(req.wdata[1:0])) && (state_q == ocal_pkg::ST_ARM);
   endproperty
   a_start_sel: assert property (p_start_sel) else $error("run selector not latched at start");

   // Go write from idle makes the block busy next cycle
   property p_start_busy;
      @(posedge clk) disable iff (srst)
      (wr_ctrl && req.wdata[2] && !busy) |=> busy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("go write did not start a run");

   // Control readback shows busy of the read cycle in bit two
   property p_go_read;
      @(posedge clk) disable iff (srst)
      (req.rd && (req.addr == ocal_pkg::OFF_CONTROL)) |=> (rdata[2] == $past(busy));
   endproperty
   a_go_read: assert property (p_go_read) else $error("go bit readback wrong");

   // With gate mode and gate low the counter stands still
   property p_gate_hold;
      @(posedge clk) disable iff (srst)
      ((state_q == ocal_pkg::ST_MEASURE) && run_gate_q && !filt_q[4] && !start) |=> $stable(count_q);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("counter moved with gate low");

   // Down-counter steps by one on a mid-window source edge
   property p_window_step;
      @(posedge clk) disable iff (srst)
      ((state_q == ocal_pkg::ST_MEASURE) && src_edge && (down_q > 16'h0001)) |=>
         (down_q == $past(down_q) - 16'h0001) && busy;
   endproperty
   a_window_step: assert property (p_window_step) else $error("window counter did not step");

   // At window end the result takes the count and the block goes idle
   property p_result_take;
      @(posedge clk) disable iff (srst)
      win_end |=> (result_q == $past(count_nxt)) && !busy;
   endproperty
   a_result_take: assert property (p_result_take) else $error("result not captured at window end");

   // High half of the result at the upper address
   property p_result_hi;
      @(posedge clk) disable iff (srst)
      (req.rd && (req.addr == ocal_pkg::OFF_RESULT_HI)) |=> (rdata == $past(result_q[31:16]));
   endproperty
   a_result_hi: assert property (p_result_hi) else $error("high result half wrong");

   // Registers read zero after reset
   property p_reset_zero;
      @(posedge clk)
      $past(srst) |-> (sel_q == 2'h0) && !gate_sel_q && !busy && (window_q == 16'h0000) && (result_q == 32'h0000_0000);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("state not zero after reset");

   // Result holds outside the window end
   property p_result_stable;
      @(posedge clk) disable iff (srst)
      !win_end |=> $stable(result_q);
   endproperty
   a_result_stable: assert property (p_result_stable) else $error("result changed mid-run");

endmodule
`default_nettype wire

// file: ocal_calib_test.sv
`timescale 1ns/1ps
`default_nettype none
module ocal_calib_test;

   // ************************************************************
   // Stimulus and observation signals
   // ************************************************************
   logic clk = 1'b0;
   logic srst = 1'b1;
   ocal_pkg::ocal_req_t req = '0;
   logic [15:0] rdata;
   logic [3:0] osc_v = 4'h0;
   logic ext_gate = 1'b0;
   logic irq;
   int err_count = 0;
   int n_checks = 0;
   int seed = 32'h0000_30fe;
   int per [4] = '{4, 6, 8, 10};
   int cnt [4] = '{0, 0, 0, 0};
   logic [31:0] last_res = 32'h0000_0000;
   logic [15:0] v;

   // 40 MHz reference clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   // Device under test
   ocal_calib i_dut (
      .clk(clk),
      .srst(srst),
      .req(req),
      .rdata(rdata),
      .osc(ocal_pkg::ocal_osc_t'(osc_v)),
      .ext_gate(ext_gate),
      .irq(irq)
   );

   // Free-running oscillators, a different whole period on each pin
   always @(posedge clk) begin
      for (int j = 0; j < 4; j++) begin
         if (cnt[j] == per[j] / 2 - 1) begin
            cnt[j] <= 0;
            osc_v[j] <= ~osc_v[j];
         end else begin
            cnt[j] <= cnt[j] + 1;
         end
      end
   end

   // ************************************************************
   // Bus cycles and comparison
   // ************************************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask

   // Read data stand in the cycle after the strobe only
   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      req <= '0;
      #1 d = rdata;
   endtask

   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ************************************************************
   // One measurement run against the reference model
   // ************************************************************
   task automatic run(input logic [1:0] s, input logic g, input logic [15:0] n, input logic poke);
      logic [31:0] expv;
      logic [1:0] s2;
      int k;
      // Model: window of n source periods, zero treated as one, gated counting
      expv = 32'((n == 16'h0000) ? 16'h0001 : n) * 32'(per[s]);
      if (g && !ext_gate) begin
         expv = 32'h0000_0000;
      end
      s2 = poke ? ~s : s;
      wr(ocal_pkg::OFF_WINDOW, n);
      wr(ocal_pkg::OFF_CONTROL, {12'h000, g, 1'b1, s});
      // Old result first, a one-period window may already end a few cycles later
      rd(ocal_pkg::OFF_RESULT_LO, v);
      chk("result held at start", {16'h0000, last_res[15:0]}, v);
      rd(ocal_pkg::OFF_CONTROL, v);
      chk("control while running", {16'h0000, 12'h000, g, 1'b1, s}, v);
      rd(ocal_pkg::OFF_WINDOW, v);
      chk("window length", {16'h0000, n}, v);
      // A second go while busy must not restart the run
      if (poke) begin
         wr(ocal_pkg::OFF_CONTROL, {12'h000, g, 1'b1, s2});
      end
      k = 0;
      do begin
         rd(ocal_pkg::OFF_CONTROL, v);
         k++;
      end while (v[2] === 1'b1 && k < 50000);
      chk("control after run", {16'h0000, 12'h000, g, 1'b0, s2}, v);
      rd(ocal_pkg::OFF_RESULT_LO, v);
      chk("result low", {16'h0000, expv[15:0]}, v);
      rd(ocal_pkg::OFF_RESULT_HI, v);
      chk("result high", {16'h0000, expv[31:16]}, v);
      last_res = expv;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      logic [15:0] n;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      // Every register and one unmapped address read zero after reset
      for (int i = 0; i < 7; i++) begin
         rd(ocal_pkg::OFF_CONTROL + 32'(2 * i), v);
         chk("reset value", 32'h0000_0000, v);
      end
      // Each source code with a random window, then a zero window
      for (int i = 0; i < 5; i++) begin
         n = (i == 4) ? 16'h0000 : 16'(($random(seed) & 15) + 1);
         run(2'(i), 1'b0, n, 1'b0);
      end
      // External gate held open, then held shut
      @(posedge clk);
      ext_gate <= 1'b1;
      repeat (8) @(posedge clk);
      run(2'h2, 1'b1, 16'h0005, 1'b0);
      @(posedge clk);
      ext_gate <= 1'b0;
      repeat (8) @(posedge clk);
      run(2'h1, 1'b1, 16'h0003, 1'b0);
      // Long window whose total spills into the high half, go repeated while busy
      run(2'h3, 1'b0, 16'h1C00, 1'b1);
      // Done status, masking and write-one-to-clear
      rd(ocal_pkg::OFF_IRQ_STATUS, v);
      chk("done status", 32'h0000_0001, v);
      chk("irq while masked", 32'h0000_0000, irq);
      wr(ocal_pkg::OFF_IRQ_MASK, 16'h0001);
      #1 chk("irq unmasked", 32'h0000_0001, irq);
      wr(ocal_pkg::OFF_IRQ_STATUS, 16'h0001);
      #1 chk("irq after clear", 32'h0000_0000, irq);
      rd(ocal_pkg::OFF_IRQ_STATUS, v);
      chk("status after clear", 32'h0000_0000, v);
      print_verdict;
   end

   // Watchdog well beyond the longest expected run
   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      print_verdict;
   end

endmodule
`default_nettype wire

// file: ocal_pkg.sv
`default_nettype none
package ocal_pkg;

   // ************************************************************
   // Bus and register widths
   // ************************************************************
   localparam int ADDR_W = 32;
   localparam int DATA_W = 16;
   localparam int RES_W = 32;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [31:0] OFF_CONTROL = 32'h5000_1600;
   localparam logic [31:0] OFF_WINDOW = 32'h5000_1602;
   localparam logic [31:0] OFF_RESULT_LO = 32'h5000_1604;
   localparam logic [31:0] OFF_RESULT_HI = 32'h5000_1606;
   localparam logic [31:0] OFF_IRQ_STATUS = 32'h5000_1608;
   localparam logic [31:0] OFF_IRQ_MASK = 32'h5000_160A;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_GO_BIT = 2;
   localparam int CTRL_GATE_BIT = 3;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_OVF_BIT = 1;
   localparam int IRQ_W = 2;

   // ************************************************************
   // Source selector codes, also the index into the pin vector
   // ************************************************************
   localparam logic [1:0] SRC_SLOW_RC = 2'h0;
   localparam logic [1:0] SRC_FAST_RC = 2'h1;
   localparam logic [1:0] SRC_SLOW_XTAL = 2'h2;
   localparam logic [1:0] SRC_EXT_RC = 2'h3;
   localparam int PIN_GATE = 4;
   localparam int PIN_N = 5;

   // ************************************************************
   // Reset values and counts
   // ************************************************************
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] WINDOW_RST = 16'h0000;
   localparam logic [31:0] RESULT_RST = 32'h0000_0000;
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam logic [15:0] WINDOW_LAST = 16'h0001;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [31:0] addr;
      logic [15:0] wdata;
   } ocal_req_t;

   typedef struct packed {
      logic ext_rc;
      logic slow_xtal;
      logic fast_rc;
      logic slow_rc;
   } ocal_osc_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARM,
      ST_MEASURE
   } ocal_state_t;

endpackage
`default_nettype wire
